// ### hw/uncl_params.svh
// Register numbers, field positions, reset values and limits of the node configuration bank
`ifndef UNCL_PARAMS_SVH
`define UNCL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------------------
`define UNCL_REG_IDENT 8'h00
`define UNCL_REG_NODE_CFG 8'h04
`define UNCL_REG_NODE_ID 8'h05
`define UNCL_REG_CLK_FREQ 8'h51
`define UNCL_REG_LINK_CTRL 8'h80

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UNCL_CFG_LOCK_BIT 31
`define UNCL_CFG_HDR_BIT 0
`define UNCL_LINK_RX_ERR_BIT 27
`define UNCL_LINK_RX_CREDIT_BIT 26
`define UNCL_LINK_TX_CREDIT_BIT 25
`define UNCL_LINK_GREET_BIT 24
`define UNCL_LINK_RX_RESET_BIT 23
`define UNCL_LINK_SYM_GAP_MSB 21
`define UNCL_LINK_SYM_GAP_LSB 11
`define UNCL_LINK_TOK_GAP_MSB 10
`define UNCL_LINK_TOK_GAP_LSB 0

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define UNCL_CLK_FREQ_RESET 7'h19
`define UNCL_CLK_FREQ_MIN 7'h05
`define UNCL_CLK_FREQ_MAX 7'h64
`define UNCL_GAP_RESET 11'h001
`define UNCL_NODE_ID_RESET 16'h0000

`endif

// ### hw/uncl_pkg.sv
// Types shared by the node configuration bank
package uncl_pkg;

    // Configuration-space request
    typedef struct packed {
        logic [7:0] num;
        logic write;
        logic [31:0] wdata;
    } uncl_req_t;

    // Link gap settings passed to the transmitter
    typedef struct packed {
        logic [10:0] symbol_gap_count;
        logic [10:0] token_gap_count;
    } uncl_gaps_t;

    typedef enum logic [1:0] {
        UNCL_IDLE = 2'h0,
        UNCL_ANSWER = 2'h1
    } uncl_state_t;

endpackage

// ### hw/uncl_freq_check.sv
// Range check of a clock frequency write
`timescale 1ns/1ps
`default_nettype none
`include "uncl_params.svh"

module uncl_freq_check (
    // Written value
    input wire logic [31:0] value_in,
    // Result
    output logic valid_out
);

    // ------------------------------------------------------------------------
    // Check
    // ------------------------------------------------------------------------
    // Upper bits must be zero too, or a wide value would alias into range
    assign valid_out = (value_in[31:7] == 25'h0000000)
        && (value_in[6:0] >= `UNCL_CLK_FREQ_MIN)
        && (value_in[6:0] <= `UNCL_CLK_FREQ_MAX); // [RL7]

endmodule
`default_nettype wire

// ### hw/uncl_bank.sv
// Node configuration register bank with link control and status
//
// Contract
// [RL1] Registers reached only by configuration transactions
// [RL2] Read-only identification word: chip, revision, version
// [RL3] Config bit 0 selects one or three-byte headers
// [RL4] Config bit 31 locks config and link writes
// [RL5] Sixteen-bit node identifier, resets to zero
// [RL6] Clock frequency field in MHz, reset 25
// [RL7] Out-of-range frequency writes ignored and NACKed
// [RL8] Configurer writes frequency at start and changes
// [RL9] Link bit 27 shows receive error
// [RL10] Link bit 26 shows credit granted remotely
// [RL11] Link bit 25 shows local transmit credit
// [RL12] Bit 24 clears credit, sends greeting token
// [RL13] Bit 23 resets link receiver
// [RL14] Symbol gap field 21:11, count minus one
// [RL15] Token gap field 10:0, count minus one
// [RL16] Reserved and write-only bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "uncl_params.svh"

module uncl_bank #(
    // Arbitrary identification values, not those of any part
    parameter logic [7:0] CHIP_CODE = 8'hA5,
    parameter logic [7:0] BLOCK_REVISION = 8'h01,
    parameter logic [7:0] BLOCK_VERSION = 8'h01
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // Configuration-space request
    input wire logic REQ_VALID_IN,
    input wire uncl_pkg::uncl_req_t REQ_IN,
    // Configuration-space answer
    output logic ACK_VALID_OUT,
    output logic ACK_NACK_OUT,
    output logic [31:0] ACK_RDATA_OUT,
    // Link status from the link logic
    input wire logic LINK_RX_ERROR_IN,
    input wire logic LINK_RX_CREDIT_IN,
    input wire logic LINK_TX_CREDIT_IN,
    // Link control to the link logic
    output logic HEADER_ONE_BYTE_OUT,
    output logic [15:0] NODE_IDENTIFIER_OUT,
    output logic [6:0] CLOCK_FREQUENCY_OUT,
    output uncl_pkg::uncl_gaps_t GAPS_OUT,
    output logic SEND_GREETING_TRIGGER_OUT,
    output logic LINK_RX_RESET_OUT
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic header_one_byte;
    logic write_lock;
    logic [15:0] node_identifier;
    logic [6:0] clock_frequency;
    logic [10:0] symbol_gap_count;
    logic [10:0] token_gap_count;
    logic greet_pulse;
    logic rx_reset_pulse;
    logic freq_ok;
    logic wr;
    logic rd;
    uncl_pkg::uncl_state_t state;
    logic [31:0] rdata;
    logic nack;
    logic [31:0] next_rdata;
    logic next_nack;

    // ------------------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------------------
    // Link status comes from link logic that may run off another clock
    logic [2:0] stat_meta;
    logic [2:0] stat_sync;

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            stat_meta <= 3'h0;
            stat_sync <= 3'h0;
        end
        else
        begin
            stat_meta <= {LINK_RX_ERROR_IN, LINK_RX_CREDIT_IN, LINK_TX_CREDIT_IN};
            stat_sync <= stat_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    // Only the configuration-space port reaches these registers
    assign wr = REQ_VALID_IN && REQ_IN.write; // [RL1]
    assign rd = REQ_VALID_IN && !REQ_IN.write; // [RL1]

    function automatic logic hit(input logic [7:0] num, input logic [7:0] reg_num);
        hit = (num == reg_num);
    endfunction

    uncl_freq_check u_freq_check (
        .value_in(REQ_IN.wdata),
        .valid_out(freq_ok)
    );

    // ------------------------------------------------------------------------
    // Node configuration
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            header_one_byte <= 1'b0; // [RL3]
            write_lock <= 1'b0; // [RL4]
        end
        else if (wr && !write_lock && hit(REQ_IN.num, `UNCL_REG_NODE_CFG))
        begin
            header_one_byte <= REQ_IN.wdata[`UNCL_CFG_HDR_BIT]; // [RL3]
            write_lock <= REQ_IN.wdata[`UNCL_CFG_LOCK_BIT]; // [RL4]
        end
    end

    // ------------------------------------------------------------------------
    // Node identifier
    // ------------------------------------------------------------------------
    // Not covered by the lock, which names only config and link registers
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            node_identifier <= `UNCL_NODE_ID_RESET; // [RL5]
        end
        else if (wr && hit(REQ_IN.num, `UNCL_REG_NODE_ID))
        begin
            node_identifier <= REQ_IN.wdata[15:0]; // [RL5]
        end
    end

    // ------------------------------------------------------------------------
    // Clock frequency
    // ------------------------------------------------------------------------
    // The configurer must rewrite this whenever the oscillator changes
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            clock_frequency <= `UNCL_CLK_FREQ_RESET; // [RL6]
        end
        else if (wr && freq_ok && hit(REQ_IN.num, `UNCL_REG_CLK_FREQ))
        begin
            clock_frequency <= REQ_IN.wdata[6:0]; // [RL6] [RL7] [RL8]
        end
    end

    // ------------------------------------------------------------------------
    // Link control
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            symbol_gap_count <= `UNCL_GAP_RESET; // [RL14]
            token_gap_count <= `UNCL_GAP_RESET; // [RL15]
        end
        else if (wr && !write_lock && hit(REQ_IN.num, `UNCL_REG_LINK_CTRL)) // [RL4]
        begin
            symbol_gap_count <=
                REQ_IN.wdata[`UNCL_LINK_SYM_GAP_MSB:`UNCL_LINK_SYM_GAP_LSB]; // [RL14]
            token_gap_count <=
                REQ_IN.wdata[`UNCL_LINK_TOK_GAP_MSB:`UNCL_LINK_TOK_GAP_LSB]; // [RL15]
        end
    end

    // One-cycle strobes to the link logic
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            greet_pulse <= 1'b0;
            rx_reset_pulse <= 1'b0;
        end
        else
        begin
            greet_pulse <= wr && !write_lock && hit(REQ_IN.num, `UNCL_REG_LINK_CTRL)
                && REQ_IN.wdata[`UNCL_LINK_GREET_BIT]; // [RL12]
            rx_reset_pulse <= wr && !write_lock && hit(REQ_IN.num, `UNCL_REG_LINK_CTRL)
                && REQ_IN.wdata[`UNCL_LINK_RX_RESET_BIT]; // [RL13]
        end
    end

    // ------------------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h00000000; // [RL16]
        next_nack = 1'b0;
        if (rd)
        begin
            case (REQ_IN.num)
                `UNCL_REG_IDENT:
                    next_rdata = {CHIP_CODE, 8'h00, BLOCK_REVISION, BLOCK_VERSION}; // [RL2]
                `UNCL_REG_NODE_CFG:
                    next_rdata = {write_lock, 30'h00000000, header_one_byte};
                `UNCL_REG_NODE_ID:
                    next_rdata = {16'h0000, node_identifier};
                `UNCL_REG_CLK_FREQ:
                    next_rdata = {25'h0000000, clock_frequency};
                `UNCL_REG_LINK_CTRL:
                    // Write-only bits 24 and 23 read zero
                    next_rdata = {4'h0, stat_sync, 3'h0,
                        symbol_gap_count, token_gap_count}; // [RL9] [RL10] [RL11] [RL16]
                default:
                    next_nack = 1'b1;
            endcase
        end
        else if (wr)
        begin
            case (REQ_IN.num)
                `UNCL_REG_CLK_FREQ:
                    next_nack = !freq_ok; // [RL7]
                `UNCL_REG_IDENT, `UNCL_REG_NODE_CFG, `UNCL_REG_NODE_ID,
                `UNCL_REG_LINK_CTRL:
                    next_nack = 1'b0;
                default:
                    next_nack = 1'b1;
            endcase
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            state <= uncl_pkg::UNCL_IDLE;
            rdata <= 32'h00000000;
            nack <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            nack <= next_nack;
            case (state)
                uncl_pkg::UNCL_IDLE:
                    state <= REQ_VALID_IN ? uncl_pkg::UNCL_ANSWER : uncl_pkg::UNCL_IDLE;
                uncl_pkg::UNCL_ANSWER:
                    state <= REQ_VALID_IN ? uncl_pkg::UNCL_ANSWER : uncl_pkg::UNCL_IDLE;
                default:
                    state <= uncl_pkg::UNCL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign ACK_VALID_OUT = (state == uncl_pkg::UNCL_ANSWER);
    assign ACK_NACK_OUT = nack;
    assign ACK_RDATA_OUT = rdata;
    assign HEADER_ONE_BYTE_OUT = header_one_byte; // [RL3]
    assign NODE_IDENTIFIER_OUT = node_identifier;
    assign CLOCK_FREQUENCY_OUT = clock_frequency;
    assign GAPS_OUT = '{symbol_gap_count: symbol_gap_count, token_gap_count: token_gap_count};
    assign SEND_GREETING_TRIGGER_OUT = greet_pulse; // [RL12]
    assign LINK_RX_RESET_OUT = rx_reset_pulse; // [RL13]

endmodule
`default_nettype wire

// ### dv/uncl_properties.sv
// Port checks of the node configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "uncl_params.svh"

module uncl_properties #(
    parameter logic [7:0] CHIP_CODE = 8'hA5,
    parameter logic [7:0] BLOCK_REVISION = 8'h01,
    parameter logic [7:0] BLOCK_VERSION = 8'h01
) (
    // Clock, reset and request
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic REQ_VALID_IN,
    input wire uncl_pkg::uncl_req_t REQ_IN,
    // Answer and controls
    input wire logic ACK_VALID_OUT,
    input wire logic ACK_NACK_OUT,
    input wire logic [31:0] ACK_RDATA_OUT,
    input wire logic HEADER_ONE_BYTE_OUT,
    input wire logic [6:0] CLOCK_FREQUENCY_OUT,
    input wire uncl_pkg::uncl_gaps_t GAPS_OUT,
    input wire logic SEND_GREETING_TRIGGER_OUT,
    input wire logic LINK_RX_RESET_OUT
);
    logic locked;
    wire logic wr = REQ_VALID_IN && REQ_IN.write;
    wire logic [31:0] wd = REQ_IN.wdata;
    wire logic cfg_w = wr && REQ_IN.num == `UNCL_REG_NODE_CFG;
    wire logic frq_w = wr && REQ_IN.num == `UNCL_REG_CLK_FREQ;
    wire logic lnk_w = wr && REQ_IN.num == `UNCL_REG_LINK_CTRL && !locked;
    wire logic frq_ok = wd >= `UNCL_CLK_FREQ_MIN && wd <= `UNCL_CLK_FREQ_MAX;
    wire logic id_rd = REQ_VALID_IN && !REQ_IN.write && REQ_IN.num == `UNCL_REG_IDENT;

    // ------------------------------------------------------------------
    // Lock tracked from requests, since it has no port of its own
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            locked <= 1'h0;
        else if (cfg_w && wd[31])
            locked <= 1'h1;
    end

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    sequence one_pulse(sig);
        sig ##1 !sig;
    endsequence

    chk_ack_latency:
        assert property (ACK_VALID_OUT == $past(REQ_VALID_IN)) else $error("ack timing");
    chk_ident_word:
        assert property (id_rd |=> ACK_RDATA_OUT ==
            {CHIP_CODE, 8'h00, BLOCK_REVISION, BLOCK_VERSION}) else $error("ident word");
    chk_header_write:
        assert property (cfg_w && !locked |=> HEADER_ONE_BYTE_OUT == $past(wd[0]))
        else $error("header bit");
    chk_lock_freeze:
        assert property (wr && locked |=> $stable(HEADER_ONE_BYTE_OUT) && $stable(GAPS_OUT)
            && !SEND_GREETING_TRIGGER_OUT && !LINK_RX_RESET_OUT) else $error("lock");
    chk_freq_take:
        assert property (frq_w && frq_ok |=> !ACK_NACK_OUT
            && CLOCK_FREQUENCY_OUT == $past(wd[6:0])) else $error("freq take");
    chk_freq_refuse:
        assert property (frq_w && !frq_ok |=> ACK_NACK_OUT && $stable(CLOCK_FREQUENCY_OUT))
        else $error("freq refuse");
    chk_greet_pulse:
        assert property (lnk_w && wd[24] |=> one_pulse(SEND_GREETING_TRIGGER_OUT))
        else $error("greeting pulse");
    chk_rx_reset_pulse:
        assert property (lnk_w && wd[23] |=> one_pulse(LINK_RX_RESET_OUT))
        else $error("rx reset pulse");
    chk_gap_write:
        assert property (lnk_w |=> GAPS_OUT == $past(wd[21:0])) else $error("gaps");
endmodule

bind uncl_bank uncl_properties #(.CHIP_CODE(CHIP_CODE), .BLOCK_REVISION(BLOCK_REVISION),
    .BLOCK_VERSION(BLOCK_VERSION)) uncl_properties_i (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN), .ACK_VALID_OUT(ACK_VALID_OUT),
    .ACK_NACK_OUT(ACK_NACK_OUT), .ACK_RDATA_OUT(ACK_RDATA_OUT),
    .HEADER_ONE_BYTE_OUT(HEADER_ONE_BYTE_OUT), .CLOCK_FREQUENCY_OUT(CLOCK_FREQUENCY_OUT),
    .GAPS_OUT(GAPS_OUT), .SEND_GREETING_TRIGGER_OUT(SEND_GREETING_TRIGGER_OUT),
    .LINK_RX_RESET_OUT(LINK_RX_RESET_OUT));
`default_nettype wire

// ### dv/uncl_link_model.sv
// Behavioural far end of the link, driving the status levels
`timescale 1ns/1ps
`default_nettype none

module uncl_link_model (
    // Clock, reset and pulses from the bank
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic greet_in,
    input wire logic rx_reset_in,
    // Commands from the bench
    input wire logic err_cmd_in,
    input wire logic credit_cmd_in,
    // Status levels
    output logic err_out,
    output logic rx_credit_out,
    output logic tx_credit_out
);
    // Error stays up until the receiver is reset, as a real receiver would
    always_ff @(posedge clk_in)
        err_out <= rst_n_in && !rx_reset_in && (err_out || err_cmd_in);
    always_ff @(posedge clk_in)
        rx_credit_out <= rst_n_in && credit_cmd_in;
    always_ff @(posedge clk_in)
        tx_credit_out <= rst_n_in && !greet_in && (tx_credit_out || credit_cmd_in);
endmodule
`default_nettype wire

// ### dv/test_uncl_bank.sv
// Self-checking bench of the node configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "uncl_params.svh"

module test_uncl_bank;
    localparam logic [31:0] IDENT = 32'h3C00_0702;
    logic clk, rst_n, req_valid, err_cmd, credit_cmd, nk;
    logic ack_valid, ack_nack, hdr, greet, rx_rst, err, rx_cr, tx_cr;
    logic [31:0] rdata, rd;
    logic [15:0] node_id;
    logic [6:0] freq;
    uncl_pkg::uncl_req_t req;
    uncl_pkg::uncl_gaps_t gaps;
    int fails, n_checks, cyc;

    uncl_bank #(.CHIP_CODE(8'h3C), .BLOCK_REVISION(8'h07), .BLOCK_VERSION(8'h02)) uncl_bank_i (
        .CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(req_valid), .REQ_IN(req),
        .ACK_VALID_OUT(ack_valid), .ACK_NACK_OUT(ack_nack), .ACK_RDATA_OUT(rdata),
        .LINK_RX_ERROR_IN(err), .LINK_RX_CREDIT_IN(rx_cr), .LINK_TX_CREDIT_IN(tx_cr),
        .HEADER_ONE_BYTE_OUT(hdr), .NODE_IDENTIFIER_OUT(node_id), .CLOCK_FREQUENCY_OUT(freq),
        .GAPS_OUT(gaps), .SEND_GREETING_TRIGGER_OUT(greet), .LINK_RX_RESET_OUT(rx_rst));
    uncl_link_model uncl_link_model_i (.clk_in(clk), .rst_n_in(rst_n), .greet_in(greet),
        .rx_reset_in(rx_rst), .err_cmd_in(err_cmd), .credit_cmd_in(credit_cmd),
        .err_out(err), .rx_credit_out(rx_cr), .tx_credit_out(tx_cr));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Hang guard: the whole run needs about 60 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request; the answer is registered on the taking edge and read at the next falling edge
    task automatic acc(input logic [7:0] n, input logic w, input logic [31:0] d);
        @(negedge clk);
        req_valid = 1'h1;
        req = '{num: n, write: w, wdata: d};
        @(negedge clk);
        req_valid = 1'h0;
        check(ack_valid, 1'h1);
        rd = rdata;
        nk = ack_nack;
    endtask

    task automatic t_reset();
        check({hdr, node_id, freq, gaps}, {1'h0, 16'h0, 7'h19, 22'h000801});
        acc(`UNCL_REG_IDENT, 1'h1, 32'hFFFF_FFFF);
        acc(`UNCL_REG_IDENT, 1'h0, 32'h0);
        check(rd, IDENT);
        acc(`UNCL_REG_LINK_CTRL, 1'h0, 32'h0);
        check(rd, 32'h0000_0801);
        acc(8'h03, 1'h0, 32'h0);
        check({nk, rd}, {1'h1, 32'h0});
    endtask

    task automatic t_freq();
        logic [31:0] v [6] = '{32'h04, 32'h05, 32'h65, 32'h64, 32'h85, 32'h32};
        logic [6:0] e;
        logic ok;
        e = 7'h19;
        foreach (v[i])
        begin
            ok = v[i] >= 32'h05 && v[i] <= 32'h64;
            acc(`UNCL_REG_CLK_FREQ, 1'h1, v[i]);
            if (ok)
                e = v[i][6:0];
            check({nk, freq}, {!ok, e});
        end
        acc(`UNCL_REG_CLK_FREQ, 1'h0, 32'h0);
        check(rd, {25'h0, e});
    endtask

    task automatic t_node();
        acc(`UNCL_REG_NODE_ID, 1'h1, 32'hFFFF_FFFF);
        check(node_id, 16'hFFFF);
        acc(`UNCL_REG_NODE_ID, 1'h0, 32'h0);
        check(rd, 32'h0000_FFFF);
    endtask

    task automatic t_link();
        err_cmd = 1'h1;
        credit_cmd = 1'h1;
        repeat (4) @(negedge clk);
        err_cmd = 1'h0;
        acc(`UNCL_REG_LINK_CTRL, 1'h0, 32'h0);
        check(rd, 32'h0E00_0801);
        credit_cmd = 1'h0;
        acc(`UNCL_REG_LINK_CTRL, 1'h1, 32'hFFDF_F802);
        check({greet, rx_rst, gaps}, {2'h3, 11'h3FF, 11'h002});
        @(negedge clk);
        check({greet, rx_rst}, 2'h0);
        repeat (4) @(negedge clk);
        acc(`UNCL_REG_LINK_CTRL, 1'h0, 32'h0);
        check(rd, 32'h001F_F802);
    endtask

    task automatic t_lock();
        acc(`UNCL_REG_NODE_CFG, 1'h1, 32'h7FFF_FFFF);
        acc(`UNCL_REG_NODE_CFG, 1'h0, 32'h0);
        check({hdr, rd}, {1'h1, 32'h1});
        acc(`UNCL_REG_NODE_CFG, 1'h1, 32'h8000_0000);
        acc(`UNCL_REG_NODE_CFG, 1'h1, 32'h0000_0001);
        check({nk, hdr}, 2'h0);
        acc(`UNCL_REG_LINK_CTRL, 1'h1, 32'h0180_0000);
        check({greet, rx_rst, gaps}, {2'h0, 11'h3FF, 11'h002});
        acc(`UNCL_REG_NODE_CFG, 1'h0, 32'h0);
        check(rd, 32'h8000_0000);
    endtask

    task automatic complete_run();
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        rst_n = 1'h0;
        req_valid = 1'h0;
        req = '0;
        err_cmd = 1'h0;
        credit_cmd = 1'h0;
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        t_reset();
        t_freq();
        t_node();
        t_link();
        t_lock();
        complete_run();
    end
endmodule
`default_nettype wire
